// ==== cs_unit_pkg.sv ====
// constants, register map and command codes of the chip-select unit
package cs_unit_pkg;
    // register bus
    localparam int REG_AW = 2;
    localparam int REG_DW = 8;
    localparam logic [1:0] OFF_WINDOW_CONTROL = 2'h0;
    localparam logic [1:0] OFF_TYPE_CONTROL = 2'h1;
    localparam logic [1:0] OFF_BASE_LOW = 2'h2;
    localparam logic [1:0] OFF_BASE_HIGH = 2'h3;
    // window control fields
    localparam int TYPE_LSB = 0;
    localparam int TYPE_MSB = 1;
    localparam int SIZE_LSB = 2;
    localparam int SIZE_MSB = 6;
    localparam logic [4:0] SIZE_CODE_MAX = 5'h10;
    // type specific control fields
    localparam int WAIT_MSB = 2;
    localparam int SELF_REFRESH_BIT = 2;
    localparam int ACCESS_MODE_MSB = 1;
    localparam int INIT_FLAG_BIT = 7;
    localparam logic [2:0] TYPE_CTRL_RESET = 3'h0;
    // base address fields: register bits 15:4 hold address bits 23:12
    localparam int BASE_W = 12;
    localparam int BASE_ADDR_LSB = 12;
    localparam logic [11:0] BASE_RESET = 12'h000;
    // external address
    localparam int ADDR_W = 24;
    localparam int ADDR_CMP_LSB = 8;
    // interface types
    localparam logic [1:0] TYPE_DISABLED = 2'h0;
    localparam logic [1:0] TYPE_SRAM = 2'h1;
    localparam logic [1:0] TYPE_SRAM_LPC = 2'h2;
    localparam logic [1:0] TYPE_SDRAM = 2'h3;
    localparam logic [7:0] WINDOW_CTRL_RESET = 8'h00;
    // sdram access modes
    localparam logic [1:0] ACC_NORMAL = 2'h0;
    localparam logic [1:0] ACC_LOAD_MODE = 2'h1;
    // only this channel may drive an sdram
    localparam int SDRAM_CHANNEL = 3;
    // peripheral double clock as an enable: one pulse every PER2_DIV cycles
    localparam int PER2_DIV = 2;
    localparam int CNT_W = 14;
    // sdram commands
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_PRECHARGE_ALL = 3'h1;
    localparam logic [2:0] CMD_AUTO_REFRESH = 3'h2;
    localparam logic [2:0] CMD_LOAD_MODE = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h4;
    localparam logic [2:0] CMD_WRITE = 3'h5;
    localparam logic [2:0] CMD_SELF_REFRESH = 3'h6;
    localparam logic [2:0] CMD_SELF_REFRESH_EXIT = 3'h7;
endpackage

// ==== cs_window_match.sv ====
// address window comparator of one chip select
`timescale 1ns/1ps
module cs_window_match
(
    // configuration
    input wire logic [1:0] if_type_i,
    input wire logic [4:0] window_size_code_i,
    input wire logic [cs_unit_pkg::BASE_W-1:0] window_base_address_i,
    // address under test
    input wire logic [cs_unit_pkg::ADDR_W-1:0] addr_i,
    output logic hit_o
);
    import cs_unit_pkg::*;

    logic [ADDR_W-1:0] base_full;
    logic [ADDR_W-1:0] cmp_mask;

    // base bits below 12 are zero; bits below the compared range are ignored
    assign base_full = {window_base_address_i, {BASE_ADDR_LSB{1'b0}}};

    // bit i is compared when i >= 8 + size code
    always_comb
    begin
        cmp_mask = '0;
        for (int i = ADDR_CMP_LSB; i < ADDR_W; i++)
        begin
            cmp_mask[i] = (32'(i) >= 32'(ADDR_CMP_LSB) + 32'(window_size_code_i));
        end
    end

    // reserved size codes never match, a disabled select never fires
    assign hit_o = (if_type_i != TYPE_DISABLED)
        && (window_size_code_i <= SIZE_CODE_MAX)
        && (((addr_i ^ base_full) & cmp_mask) == '0);
endmodule // cs_window_match

// ==== tick_down_counter.sv ====
// loadable down counter stepped by an enable pulse
`timescale 1ns/1ps
module tick_down_counter
#(
    parameter int W = 14
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    input wire logic tick_i,
    // status
    output logic zero_o
);
    logic [W-1:0] count_reg;

    // load wins over counting
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            count_reg <= '0;
        else if (load_i)
            count_reg <= value_i;
        else if (tick_i && count_reg != '0)
            count_reg <= count_reg - W'(1);
    end

    assign zero_o = (count_reg == '0);
endmodule // tick_down_counter

// ==== cs_channel.sv ====
// one chip-select channel: registers, window decode, wait states, sdram control
`timescale 1ns/1ps
module cs_channel
#(
    parameter int CHANNEL = 3
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [cs_unit_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [cs_unit_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [cs_unit_pkg::REG_DW-1:0] reg_rdata_o,
    // global unit settings
    input wire logic bus_enable_i,
    input wire logic [cs_unit_pkg::CNT_W-1:0] init_delay_i,
    // access request
    input wire logic acc_req_i,
    input wire logic acc_write_i,
    input wire logic [cs_unit_pkg::ADDR_W-1:0] acc_addr_i,
    output logic acc_ack_o,
    output logic window_hit_o,
    // memory side
    output logic chip_select_o,
    output logic lpc_mode_o,
    output logic [2:0] sdram_cmd_o,
    output logic sdram_self_refresh_o
);
    import cs_unit_pkg::*;
    typedef enum logic [5:0] {S_READY = 6'b000001, S_INIT_DLY = 6'b000010,
        S_INIT_PRE = 6'b000100, S_INIT_REF = 6'b001000, S_INIT_LMR = 6'b010000,
        S_ACCESS = 6'b100000} state_t;
    state_t state_reg;
    state_t state_next;
    logic [1:0] type_reg;
    logic [4:0] window_size_code_reg;
    logic [2:0] type_ctrl_reg;
    logic [BASE_W-1:0] window_base_address_reg;
    logic sdram_init_complete_flag_reg;
    logic sr_active_reg;
    logic sel_reg;
    logic ack_reg;
    logic [2:0] cmd_reg;
    logic [REG_DW-1:0] rdata_reg;
    logic [$clog2(PER2_DIV)-1:0] div_reg;
    logic tick;
    logic [1:0] eff_type;
    logic is_sram;
    logic is_sdram;
    logic unit_on;
    logic hit;
    logic sr_request;
    logic take;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_zero;
    // sdram on any channel but three is treated as disabled
    assign eff_type = (type_reg == TYPE_SDRAM && CHANNEL != SDRAM_CHANNEL)
        ? TYPE_DISABLED : type_reg;
    assign is_sram = (eff_type == TYPE_SRAM) || (eff_type == TYPE_SRAM_LPC);
    assign is_sdram = (eff_type == TYPE_SDRAM);
    assign unit_on = bus_enable_i && (eff_type != TYPE_DISABLED);
    assign sr_request = is_sdram && type_ctrl_reg[SELF_REFRESH_BIT];
    // peripheral double clock enable
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            div_reg <= '0;
        else
            div_reg <= tick ? '0 : div_reg + 1'b1;
    end
    assign tick = (32'(div_reg) == PER2_DIV - 1);
    cs_window_match u_match
    (
        .if_type_i(eff_type),
        .window_size_code_i(window_size_code_reg),
        .window_base_address_i(window_base_address_reg),
        .addr_i(acc_addr_i),
        .hit_o(hit)
    );
    assign window_hit_o = hit && bus_enable_i;
    // sdram accesses wait for init and are held off while self refresh is requested or active;
    // a request still held in the ack cycle must not start a second access
    assign take = (state_reg == S_READY) && acc_req_i && window_hit_o && !ack_reg
        && (is_sram || (is_sdram && sdram_init_complete_flag_reg
        && !sr_active_reg && !sr_request));
    // window control register; bit 7 is not stored
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            type_reg <= WINDOW_CTRL_RESET[TYPE_MSB:TYPE_LSB];
            window_size_code_reg <= WINDOW_CTRL_RESET[SIZE_MSB:SIZE_LSB];
        end
        else if (reg_wr_i && reg_addr_i == OFF_WINDOW_CONTROL)
        begin
            type_reg <= reg_wdata_i[TYPE_MSB:TYPE_LSB];
            window_size_code_reg <= reg_wdata_i[SIZE_MSB:SIZE_LSB];
        end
    end
    // type specific control: one store serves wait count or sdram bits
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            type_ctrl_reg <= TYPE_CTRL_RESET;
        else if (reg_wr_i && reg_addr_i == OFF_TYPE_CONTROL)
            type_ctrl_reg <= reg_wdata_i[WAIT_MSB:0];
    end
    // base address: low byte carries address bits 15:12 in bits 7:4
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            window_base_address_reg <= BASE_RESET;
        else if (reg_wr_i && reg_addr_i == OFF_BASE_LOW)
            window_base_address_reg[3:0] <= reg_wdata_i[7:4];
        else if (reg_wr_i && reg_addr_i == OFF_BASE_HIGH)
            window_base_address_reg[BASE_W-1:4] <= reg_wdata_i;
    end
    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_reg <= '0;
        else if (!reg_rd_i)
            rdata_reg <= '0;
        else
        begin
            unique case (reg_addr_i)
                OFF_WINDOW_CONTROL:
                    rdata_reg <= {1'b0, window_size_code_reg, type_reg};
                OFF_TYPE_CONTROL:
                    if (is_sdram)
                        rdata_reg <= {sdram_init_complete_flag_reg, 4'h0,
                            type_ctrl_reg};
                    else
                        rdata_reg <= {5'h00, type_ctrl_reg};
                OFF_BASE_LOW:
                    rdata_reg <= {window_base_address_reg[3:0], 4'h0};
                OFF_BASE_HIGH:
                    rdata_reg <= window_base_address_reg[BASE_W-1:4];
            endcase
        end
    end
    assign reg_rdata_o = rdata_reg;
    // shared counter: init delay, then per-access wait states
    always_comb
    begin
        cnt_load = 1'b0;
        cnt_value = '0;
        if (state_reg == S_READY && unit_on && is_sdram && !sdram_init_complete_flag_reg)
        begin
            cnt_load = 1'b1;
            cnt_value = init_delay_i;
        end
        else if (take)
        begin
            cnt_load = 1'b1;
            cnt_value = is_sram ? CNT_W'(type_ctrl_reg) : '0;
        end
    end
    tick_down_counter #(.W(CNT_W)) u_count
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(cnt_load),
        .value_i(cnt_value),
        .tick_i(tick),
        .zero_o(cnt_zero)
    );
    // sequencer; losing enable or sdram type aborts init back to ready
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            S_READY:
                if (take)
                    state_next = S_ACCESS;
                else if (cnt_load)
                    state_next = S_INIT_DLY;
            S_INIT_DLY:
                if (tick && cnt_zero)
                    state_next = S_INIT_PRE;
            S_INIT_PRE:
                if (tick)
                    state_next = S_INIT_REF;
            S_INIT_REF:
                if (tick)
                    state_next = S_INIT_LMR;
            S_INIT_LMR:
                if (tick)
                    state_next = S_READY;
            S_ACCESS:
                if (tick && cnt_zero)
                    state_next = S_READY;
        endcase
        if (!unit_on || (!is_sdram && state_reg != S_ACCESS && state_reg != S_READY))
            state_next = S_READY;
    end
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_reg <= S_READY;
        else
            state_reg <= state_next;
    end
    // init complete flag: set when the mode load step ends
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sdram_init_complete_flag_reg <= 1'b0;
        else if (!unit_on || !is_sdram)
            sdram_init_complete_flag_reg <= 1'b0;
        else if (state_reg == S_INIT_LMR && tick)
            sdram_init_complete_flag_reg <= 1'b1;
    end
    // self refresh tracks the written bit, changed only while idle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sr_active_reg <= 1'b0;
        else if (!unit_on || !is_sdram)
            sr_active_reg <= 1'b0;
        else if (state_reg == S_READY && sdram_init_complete_flag_reg
            && sr_request != sr_active_reg)
            sr_active_reg <= sr_request;
    end
    assign sdram_self_refresh_o = sr_active_reg;
    // command output, one cycle per command
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cmd_reg <= CMD_NOP;
        else if (!unit_on || !is_sdram)
            cmd_reg <= CMD_NOP;
        else if (state_reg == S_INIT_PRE && tick)
            cmd_reg <= CMD_PRECHARGE_ALL;
        else if (state_reg == S_INIT_REF && tick)
            cmd_reg <= CMD_AUTO_REFRESH;
        else if (state_reg == S_INIT_LMR && tick)
            cmd_reg <= CMD_LOAD_MODE;
        else if (state_reg == S_READY && sdram_init_complete_flag_reg
            && sr_request && !sr_active_reg)
            cmd_reg <= CMD_SELF_REFRESH;
        else if (state_reg == S_READY && sdram_init_complete_flag_reg
            && !sr_request && sr_active_reg)
            cmd_reg <= CMD_SELF_REFRESH_EXIT;
        else if (take && type_ctrl_reg[ACCESS_MODE_MSB:0] == ACC_LOAD_MODE)
            cmd_reg <= CMD_LOAD_MODE;
        else if (take && type_ctrl_reg[ACCESS_MODE_MSB:0] == ACC_NORMAL)
            cmd_reg <= acc_write_i ? CMD_WRITE : CMD_READ;
        else
            cmd_reg <= CMD_NOP; // reserved access modes issue nothing
    end
    assign sdram_cmd_o = cmd_reg;
    // chip select held from take to answer, ack one cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sel_reg <= 1'b0;
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= (state_reg == S_ACCESS) && tick && cnt_zero;
            if (take)
                sel_reg <= 1'b1;
            else if (state_next == S_READY)
                sel_reg <= 1'b0;
        end
    end
    assign chip_select_o = sel_reg;
    assign acc_ack_o = ack_reg;
    assign lpc_mode_o = (eff_type == TYPE_SRAM_LPC);
    // checks
    AST_RESERVED_CTRL_A: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == OFF_WINDOW_CONTROL |=> !reg_rdata_o[7])
        else $error("window control bit 7 not zero");
    AST_BASE_LOW_RESERVED: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == OFF_BASE_LOW |=> reg_rdata_o[3:0] == 4'h0)
        else $error("base low nibble not zero");
    AST_SIZE_RESERVED: assert property (@(posedge clk_i) disable iff (!nrst_i)
        window_size_code_reg > SIZE_CODE_MAX |-> !window_hit_o)
        else $error("reserved size code matched");
    AST_TYPE_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        type_reg == TYPE_DISABLED |-> !window_hit_o)
        else $error("disabled select matched");
    AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !bus_enable_i |=> !sdram_init_complete_flag_reg)
        else $error("init flag kept while unit off");
    AST_FLAG_AFTER_SEQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(sdram_init_complete_flag_reg) |-> cmd_reg == CMD_LOAD_MODE
        && $past(state_reg) == S_INIT_LMR)
        else $error("init flag without mode load");
    AST_LOAD_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && is_sdram && type_ctrl_reg[1:0] == ACC_LOAD_MODE
        |=> cmd_reg == CMD_LOAD_MODE)
        else $error("load mode access gave other command");
    AST_NORMAL_RW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && is_sdram && type_ctrl_reg[1:0] == ACC_NORMAL
        |=> cmd_reg == (($past(acc_write_i)) ? CMD_WRITE : CMD_READ))
        else $error("normal access gave wrong command");
    AST_SR_ENTER: assert property (@(posedge clk_i) disable iff (!nrst_i)
        unit_on && state_reg == S_READY && sdram_init_complete_flag_reg
        && sr_request && !sr_active_reg |=> cmd_reg == CMD_SELF_REFRESH ##0 sr_active_reg)
        else $error("self refresh not issued");
    AST_SRAM_ZERO_WAIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && is_sram && type_ctrl_reg == 3'h0 |-> ##[2:3] acc_ack_o)
        else $error("zero wait sram access late");
    COV_SRAM_WAIT: cover property (@(posedge clk_i) disable iff (!nrst_i)
        take && is_sram && type_ctrl_reg == 3'h7 ##[1:40] acc_ack_o);
    COV_INIT_DONE: cover property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(sdram_init_complete_flag_reg));
    COV_SR_EXIT: cover property (@(posedge clk_i) disable iff (!nrst_i)
        cmd_reg == CMD_SELF_REFRESH_EXIT);
endmodule // cs_channel

// ==== mem_partner.sv ====
// far-side memory model: follows sdram commands, tracks init order and self refresh
`timescale 1ns/1ps
module mem_partner
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // command from the channel
    input wire logic [2:0] sdram_cmd_i,
    // observed memory state
    output logic init_seen_o,
    output logic in_self_refresh_o,
    output logic [2:0] last_cmd_o
);
    import cs_unit_pkg::*;
    logic [1:0] step_reg;
    // init only counts when the three commands arrive in order; any stray order stalls it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            step_reg <= 2'h0;
        else if (sdram_cmd_i == CMD_PRECHARGE_ALL)
            step_reg <= 2'h1;
        else if (sdram_cmd_i == CMD_AUTO_REFRESH && step_reg == 2'h1)
            step_reg <= 2'h2;
        else if (sdram_cmd_i == CMD_LOAD_MODE && step_reg == 2'h2)
            step_reg <= 2'h3;
    end
    assign init_seen_o = (step_reg == 2'h3);
    // keep the last real command, since each one stands a single cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            last_cmd_o <= CMD_NOP;
            in_self_refresh_o <= 1'b0;
        end
        else if (sdram_cmd_i != CMD_NOP)
        begin
            last_cmd_o <= sdram_cmd_i;
            if (sdram_cmd_i == CMD_SELF_REFRESH)
                in_self_refresh_o <= 1'b1;
            else if (sdram_cmd_i == CMD_SELF_REFRESH_EXIT)
                in_self_refresh_o <= 1'b0;
        end
    end
endmodule // mem_partner

// ==== cs_channel_bench.sv ====
// self-checking bench of one chip-select channel
`timescale 1ns/1ps
module cs_channel_bench;
    import cs_unit_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] reg_addr_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic bus_enable_i = 1'b0;
    logic [13:0] init_delay_i = 14'h0003;
    logic acc_req_i = 1'b0;
    logic acc_write_i = 1'b0;
    logic [23:0] acc_addr_i = 24'h000000;
    logic [7:0] reg_rdata_o;
    logic acc_ack_o, window_hit_o, chip_select_o, lpc_mode_o, sdram_self_refresh_o;
    logic [2:0] sdram_cmd_o, last_cmd;
    logic init_seen, in_sr;
    logic [7:0] d;
    int errors = 0;
    int n_compared = 0;
    // ctrl a, base high, base low, address, expected hit
    logic [55:0] win_tab [0:7] = '{
        {8'h11, 8'h12, 8'h30, 24'h123fff, 8'h01}, {8'h11, 8'h12, 8'h30, 24'h124000, 8'h00},
        {8'h11, 8'h12, 8'h30, 24'h122fff, 8'h00}, {8'h01, 8'h12, 8'h00, 24'h1200ff, 8'h01},
        {8'h01, 8'h12, 8'h00, 24'h120100, 8'h00}, {8'h3d, 8'h80, 8'h00, 24'h7fffff, 8'h00},
        {8'h40, 8'h00, 8'h00, 24'h000000, 8'h00}, {8'h45, 8'h00, 8'h00, 24'h000000, 8'h00}};

    // sdram type only on channel three
    cs_channel #(.CHANNEL(SDRAM_CHANNEL)) cs_channel_i (.clk_i, .nrst_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_enable_i, .init_delay_i,
        .acc_req_i, .acc_write_i, .acc_addr_i, .acc_ack_o, .window_hit_o, .chip_select_o,
        .lpc_mode_o, .sdram_cmd_o, .sdram_self_refresh_o);
    mem_partner mem_partner_i (.clk_i, .nrst_i, .sdram_cmd_i(sdram_cmd_o),
        .init_seen_o(init_seen), .in_self_refresh_o(in_sr), .last_cmd_o(last_cmd));

    // 40 MHz clock
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one-cycle strobes; the next call waits an edge so a strobe is never set twice at once
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask

    // request held up to the edge that samples ack; the channel ignores it in the ack cycle
    task automatic access(input logic [23:0] a, input logic w, output int n);
        logic sel_seen;
        @(posedge clk_i);
        acc_addr_i <= a;
        acc_write_i <= w;
        acc_req_i <= 1'b1;
        n = 0;
        sel_seen = 1'b0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
            sel_seen = sel_seen | chip_select_o;
            if (n > 40)
            begin
                errors++;
                summarize();
            end
        end while (acc_ack_o !== 1'b1);
        chk("select during access", sel_seen, 1'b1);
        @(posedge clk_i);
        acc_req_i <= 1'b0;
    endtask

    task automatic t_regs;
        for (int a = 0; a < 4; a++)
        begin
            rd(a[1:0], d);
            chk("reset value", d, 8'h00);
        end
        wr(2'h0, 8'hc1);
        rd(2'h0, d);
        chk("window control", d, 8'h41);
        wr(2'h1, 8'hff);
        rd(2'h1, d);
        chk("sram control", d, 8'h07);
        wr(2'h2, 8'hff);
        rd(2'h2, d);
        chk("base low", d, 8'hf0);
        wr(2'h3, 8'ha5);
        rd(2'h3, d);
        chk("base high", d, 8'ha5);
        $display("test done: registers");
    endtask

    task automatic t_window;
        for (int i = 0; i < 8; i++)
        begin
            wr(2'h0, win_tab[i][55:48]);
            wr(2'h3, win_tab[i][47:40]);
            wr(2'h2, win_tab[i][39:32]);
            acc_addr_i <= win_tab[i][31:8];
            @(posedge clk_i);
            #1 chk("window hit", window_hit_o, win_tab[i][0]);
        end
        wr(2'h0, 8'h42);
        #1 chk("low pin count", lpc_mode_o, 1'b1);
        chk("whole space hit", window_hit_o, 1'b1);
        @(posedge clk_i);
        bus_enable_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("hit bus off", window_hit_o, 1'b0);
        @(posedge clk_i);
        bus_enable_i <= 1'b1;
        $display("test done: window");
    endtask

    task automatic t_sram;
        int n;
        int lo;
        for (int t = 1; t <= 2; t++)
            for (int w = 0; w < 8; w += 7)
            begin
                wr(2'h0, {6'h10, t[1:0]});
                wr(2'h1, w[7:0]);
                access(24'h00abcd, t[0], n);
                // take one edge after the request, then w+1 double-clock ticks of either phase
                lo = 2 + PER2_DIV * w;
                chk("wait latency", (n >= lo && n < lo + PER2_DIV), 1'b1);
            end
        $display("test done: sram waits");
    endtask

    task automatic t_sdram;
        int n;
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h43);
        n = 0;
        do
        begin
            rd(2'h1, d);
            n++;
            if (n > 50)
            begin
                errors++;
                summarize();
            end
        end while (d[7] !== 1'b1);
        chk("init flag", d, 8'h80);
        chk("init order", init_seen, 1'b1);
        access(24'h000100, 1'b0, n);
        chk("read command", last_cmd, CMD_READ);
        access(24'h000104, 1'b1, n);
        chk("write command", last_cmd, CMD_WRITE);
        wr(2'h1, 8'h01);
        access(24'h000000, 1'b1, n);
        chk("load mode command", last_cmd, CMD_LOAD_MODE);
        // reserved access mode: no read, write or mode load may reach the memory
        wr(2'h1, 8'h02);
        access(24'h000008, 1'b0, n);
        chk("reserved mode command", last_cmd, CMD_LOAD_MODE);
        wr(2'h1, 8'h04);
        repeat (2) @(posedge clk_i);
        #1 chk("self refresh out", sdram_self_refresh_o, 1'b1);
        chk("self refresh cmd", last_cmd, CMD_SELF_REFRESH);
        chk("memory in self refresh", in_sr, 1'b1);
        wr(2'h1, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk("self refresh exit", sdram_self_refresh_o, 1'b0);
        chk("exit cmd", last_cmd, CMD_SELF_REFRESH_EXIT);
        chk("memory out of self refresh", in_sr, 1'b0);
        @(posedge clk_i);
        bus_enable_i <= 1'b0;
        rd(2'h1, d);
        chk("flag cleared", d, 8'h00);
        $display("test done: sdram");
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus_enable_i <= 1'b1;
        t_regs();
        t_window();
        t_sram();
        t_sdram();
        summarize();
    end
endmodule // cs_channel_bench
